// ---- core/bdec_cfg_regs.sv ----
// Bridge address decoder: base and limit registers of one secondary port
`timescale 1ns/10ps
`default_nettype none
`include "bdec_regs.svh"
module bdec_cfg_regs
	import bdec_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	input  wire logic        cfg_wr,
	input  wire logic [7:0]  cfg_addr,
	input  wire logic [3:0]  cfg_be,
	input  wire logic [31:0] cfg_wdata,
	output logic      [31:0] rd_data,
	bdec_win_if.cfg          win
);

	logic [3:0]  io_base_nib_q;
	logic [3:0]  io_limit_nib_q;
	logic [15:0] io_base_up_q;
	logic [15:0] io_limit_up_q;
	logic [11:0] np_base_q;
	logic [11:0] np_limit_q;
	logic [11:0] pf_base_q;
	logic [11:0] pf_limit_q;
	logic [7:0]  dw_addr;

	assign dw_addr = {cfg_addr[7:2], 2'b00};

	// ------------------------------------------------------------------------
	// I/O window
	// ------------------------------------------------------------------------
	// (RULE11) reset window zero to 0FFFh
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			io_base_nib_q  <= `BDEC_RST_IO_NIB;
			io_limit_nib_q <= `BDEC_RST_IO_NIB;
			io_base_up_q   <= `BDEC_RST_UP16;
			io_limit_up_q  <= `BDEC_RST_UP16;
		end else if (cfg_wr) begin
			// (RULE8) base bits 15:12 in upper nibble
			if (dw_addr == `BDEC_OFF_IO_BASE_LOW && cfg_be[0]) begin
				io_base_nib_q <= cfg_wdata[7:4];
			end
			// (RULE10) limit bits 15:12 likewise
			if (dw_addr == `BDEC_OFF_IO_BASE_LOW && cfg_be[1]) begin
				io_limit_nib_q <= cfg_wdata[15:12];
			end
			// (RULE9) upper base halfword fully writable
			if (dw_addr == `BDEC_OFF_IO_BASE_UP) begin
				if (cfg_be[0]) io_base_up_q[7:0] <= cfg_wdata[7:0];
				if (cfg_be[1]) io_base_up_q[15:8] <= cfg_wdata[15:8];
				if (cfg_be[2]) io_limit_up_q[7:0] <= cfg_wdata[23:16];
				if (cfg_be[3]) io_limit_up_q[15:8] <= cfg_wdata[31:24];
			end
		end
	end

	// ------------------------------------------------------------------------
	// Memory windows
	// ------------------------------------------------------------------------
	// (RULE17) non-prefetchable base and limit, bits 31:20
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			np_base_q  <= `BDEC_RST_MEM12;
			np_limit_q <= `BDEC_RST_MEM12;
		end else if (cfg_wr && dw_addr == `BDEC_OFF_NP_BASE) begin
			if (cfg_be[0]) np_base_q[3:0] <= cfg_wdata[7:4];
			if (cfg_be[1]) np_base_q[11:4] <= cfg_wdata[15:8];
			if (cfg_be[2]) np_limit_q[3:0] <= cfg_wdata[23:20];
			if (cfg_be[3]) np_limit_q[11:4] <= cfg_wdata[31:24];
		end
	end

	// (RULE18) prefetchable base and limit, same mapping
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			pf_base_q  <= `BDEC_RST_MEM12;
			pf_limit_q <= `BDEC_RST_MEM12;
		end else if (cfg_wr && dw_addr == `BDEC_OFF_PF_BASE) begin
			if (cfg_be[0]) pf_base_q[3:0] <= cfg_wdata[7:4];
			if (cfg_be[1]) pf_base_q[11:4] <= cfg_wdata[15:8];
			if (cfg_be[2]) pf_limit_q[3:0] <= cfg_wdata[23:20];
			if (cfg_be[3]) pf_limit_q[11:4] <= cfg_wdata[31:24];
		end
	end

	// ------------------------------------------------------------------------
	// Read mux and window expansion
	// ------------------------------------------------------------------------
	always_comb begin
		unique case (dw_addr)
			`BDEC_OFF_IO_BASE_LOW: rd_data = {`BDEC_RD_PAD16, io_limit_nib_q, `BDEC_IO_CAP_NIB,
				io_base_nib_q, `BDEC_IO_CAP_NIB};
			`BDEC_OFF_NP_BASE:     rd_data = {np_limit_q, `BDEC_NP_LOW_NIB, np_base_q, `BDEC_NP_LOW_NIB};
			`BDEC_OFF_PF_BASE:     rd_data = {pf_limit_q, `BDEC_PF_CAP_NIB, pf_base_q, `BDEC_PF_CAP_NIB};
			`BDEC_OFF_IO_BASE_UP:  rd_data = {io_limit_up_q, io_base_up_q};
			default:               rd_data = `BDEC_RD_UNMAPPED;
		endcase
	end

	// (RULE7) 4KB I/O granule: low base zeros, low limit ones
	assign win.io_base  = {io_base_up_q, io_base_nib_q, `BDEC_IO_BASE_PAD};
	assign win.io_limit = {io_limit_up_q, io_limit_nib_q, `BDEC_IO_LIMIT_PAD};
	assign win.np_base  = {np_base_q, `BDEC_MEM_BASE_PAD};
	assign win.np_limit = {np_limit_q, `BDEC_MEM_LIMIT_PAD};
	assign win.pf_base  = {pf_base_q, `BDEC_MEM_BASE_PAD};
	assign win.pf_limit = {pf_limit_q, `BDEC_MEM_LIMIT_PAD};

endmodule
`default_nettype wire

// ---- core/bdec_decoder.sv ----
// Bridge address decoder: top level, claims and routes per bus
`timescale 1ns/10ps
`default_nettype none
`include "bdec_regs.svh"

// Behaviour
// (RULE1) Primary hits inside windows go down; secondary misses go up, untranslated.
// (RULE2) Secondary miss on own windows but hit on other bus goes peer-to-peer.
// (RULE3) I/O goes downstream only with I/O enable; else primary I/O ignored.
// (RULE4) Without master enable all secondary I/O and memory requests are ignored.
// (RULE5) Memory goes downstream only with memory enable set.
// (RULE6) I/O base above limit disables the window: all I/O upstream.
// (RULE7) I/O window has 4KB granule over 32-bit space.
// (RULE8) Base bits 15:12 sit in upper nibble at 1Ch; lower nibble reads 1.
// (RULE9) Base bits 31:16 sit in read/write halfword at 30h.
// (RULE10) Limit laid out the same at 1Dh and 32h.
// (RULE11) Reset gives I/O window zero to 0FFFh.
// (RULE12) ISA mode below 64KB forwards only bottom 256 bytes per 1KB down.
// (RULE13) ISA mode with master enable sends upper 768 bytes upstream.
// (RULE14) Above 64KB only base and limit decide.
// (RULE15) Otherwise secondary I/O goes up only outside the window.
// (RULE16) Software sets windows before enables and changes them only when idle.
// (RULE17) Non-prefetchable window at 20h and 22h, 1MB granule.
// (RULE18) Prefetchable window at 24h and 26h, low nibbles read 1.
// (RULE19) Inside means base <= address <= limit over 32 bits.
module bdec_decoder
	import bdec_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	input  wire logic        cfg_wr,
	input  wire logic        cfg_rd,
	input  wire logic        cfg_port,
	input  wire logic [7:0]  cfg_addr,
	input  wire logic [3:0]  cfg_be,
	input  wire logic [31:0] cfg_wdata,
	output logic      [31:0] cfg_rdata,
	input  wire logic [1:0]  io_en,
	input  wire logic [1:0]  mem_en,
	input  wire logic [1:0]  master_en,
	input  wire logic [1:0]  isa_en,
	input  wire logic [2:0]  req_valid,
	input  wire logic [2:0]  req_is_io,
	input  wire logic [31:0] req_addr [3],
	output logic      [2:0]  route_valid,
	output bdec_dest_t       route_dest [3]
);

	// ------------------------------------------------------------------------
	// Configuration spaces, one per secondary port
	// ------------------------------------------------------------------------
	bdec_win_if win [2] ();

	logic [31:0] port_rd [2];
	logic [31:0] cfg_rdata_q;
	logic [2:0]  route_valid_q;
	bdec_dest_t  route_dest_q [3];
	bdec_dest_t  route_dest_d [3];
	logic [1:0]  win_hit [3];
	logic [1:0]  down_hit [3];

	genvar p;
	genvar s;
	generate
		for (p = 0; p < 2; p++) begin : g_port
			bdec_cfg_regs u_cfg (
				.sys_clk   (sys_clk),
				.rst_n     (rst_n),
				.cfg_wr    (cfg_wr && (cfg_port == 1'(p))),
				.cfg_addr  (cfg_addr),
				.cfg_be    (cfg_be),
				.cfg_wdata (cfg_wdata),
				.rd_data   (port_rd[p]),
				.win       (win[p])
			);
			for (s = 0; s < 3; s++) begin : g_src
				bdec_port_dec u_dec (
					.addr     (req_addr[s]),
					.is_io    (req_is_io[s]),
					.isa_en   (isa_en[p]),
					.io_en    (io_en[p]),
					.mem_en   (mem_en[p]),
					.win      (win[p]),
					.win_hit  (win_hit[s][p]),
					.down_hit (down_hit[s][p])
				);
			end
		end
	endgenerate

	// Read data held until the next read so software can sample late
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			cfg_rdata_q <= `BDEC_RD_UNMAPPED;
		end else if (cfg_rd) begin
			cfg_rdata_q <= cfg_port ? port_rd[1] : port_rd[0];
		end
	end

	assign cfg_rdata = cfg_rdata_q;

	// ------------------------------------------------------------------------
	// Routing decision
	// ------------------------------------------------------------------------
	// Own-window hits are local traffic and stay on that bus
	function automatic bdec_dest_t bdec_route_up(input logic master, input logic own_hit,
		input logic peer_hit, input bdec_dest_t peer_dest);
		if (!master) begin
			bdec_route_up = BDEC_DEST_NONE;
		end else if (own_hit) begin
			bdec_route_up = BDEC_DEST_NONE;
		end else if (peer_hit) begin
			bdec_route_up = peer_dest;
		end else begin
			bdec_route_up = BDEC_DEST_PRIMARY;
		end
	endfunction

	always_comb begin
		// (RULE1) primary hits forwarded down, port one first
		if (down_hit[0][0]) begin
			route_dest_d[0] = BDEC_DEST_BUS_ONE;
		end else if (down_hit[0][1]) begin
			route_dest_d[0] = BDEC_DEST_BUS_TWO;
		end else begin
			route_dest_d[0] = BDEC_DEST_NONE;
		end
		// (RULE2) (RULE4) (RULE13) (RULE15) secondary up, peer or ignored
		route_dest_d[1] = bdec_route_up(master_en[0], win_hit[1][0], down_hit[1][1], BDEC_DEST_BUS_TWO);
		route_dest_d[2] = bdec_route_up(master_en[1], win_hit[2][1], down_hit[2][0], BDEC_DEST_BUS_ONE);
	end

	// Config changes mid-transaction give undefined decode; no interlock here
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			route_valid_q <= 3'h0;
			for (int i = 0; i < 3; i++) begin
				route_dest_q[i] <= BDEC_DEST_NONE;
			end
		end else begin
			route_valid_q <= req_valid;
			for (int i = 0; i < 3; i++) begin
				if (req_valid[i]) begin
					route_dest_q[i] <= route_dest_d[i];
				end
			end
		end
	end

	assign route_valid = route_valid_q;
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			route_dest[i] = route_dest_q[i];
		end
	end

	// ------------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------------
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);

	sequence s_wr_io_up0;
		cfg_wr && !cfg_port && ({cfg_addr[7:2], 2'b00} == `BDEC_OFF_IO_BASE_UP) && (cfg_be == 4'hF);
	endsequence

	sequence s_rd_io_low;
		cfg_rd && ({cfg_addr[7:2], 2'b00} == `BDEC_OFF_IO_BASE_LOW);
	endsequence

	sequence s_one_req(logic own, logic peer);
		req_valid[1] && master_en[0] && !own && !peer;
	endsequence

	sequence s_two_req(logic own, logic peer);
		req_valid[2] && master_en[1] && !own && !peer;
	endsequence

	sequence s_wr_io_low0;
		cfg_wr && !cfg_port && ({cfg_addr[7:2], 2'b00} == `BDEC_OFF_IO_BASE_LOW);
	endsequence

	a_prim_io_gate: assert property ( // (RULE3)
		req_valid[0] && req_is_io[0] && (io_en == 2'b00) |=> route_valid[0] && route_dest[0] == BDEC_DEST_NONE)
		else $error("primary I/O claimed with I/O enable clear");

	a_sec_master_off: assert property ( // (RULE4)
		req_valid[2] && !master_en[1] |=> route_dest[2] == BDEC_DEST_NONE)
		else $error("secondary request routed with master enable clear");

	a_prim_mem_gate: assert property ( // (RULE5)
		req_valid[0] && !req_is_io[0] && (mem_en == 2'b00) |=> route_dest[0] == BDEC_DEST_NONE)
		else $error("primary memory claimed with memory enable clear");

	a_io_range_off: assert property ( // (RULE6)
		req_valid[1] && req_is_io[1] && master_en[0] && (win[0].io_base > win[0].io_limit)
		&& !down_hit[1][1] |=> route_dest[1] == BDEC_DEST_PRIMARY)
		else $error("I/O not sent upstream with windows disabled");

	a_peer_route: assert property ( // (RULE2)
		req_valid[1] && master_en[0] && !win_hit[1][0] && down_hit[1][1] |=> route_dest[1] == BDEC_DEST_BUS_TWO)
		else $error("peer hit not routed to bus two");

	a_upstream_miss: assert property ( // (RULE1)
		s_one_req(win_hit[1][0], down_hit[1][1]) |=> route_dest[1] == BDEC_DEST_PRIMARY)
		else $error("secondary miss not routed upstream");

	a_isa_upstream: assert property ( // (RULE13)
		req_valid[1] && req_is_io[1] && master_en[0] && isa_en[0] && !down_hit[1][1]
		&& ((req_addr[1] & `BDEC_ISA_REGION_MASK) == `BDEC_ZERO32)
		&& ((req_addr[1] & `BDEC_ISA_ALIAS_MASK) != `BDEC_ZERO32) |=> route_dest[1] == BDEC_DEST_PRIMARY)
		else $error("ISA alias not routed upstream");

	a_isa_no_down: assert property ( // (RULE12)
		req_valid[0] && req_is_io[0] && isa_en == 2'b11
		&& ((req_addr[0] & `BDEC_ISA_REGION_MASK) == `BDEC_ZERO32)
		&& ((req_addr[0] & `BDEC_ISA_ALIAS_MASK) != `BDEC_ZERO32) |=> route_dest[0] == BDEC_DEST_NONE)
		else $error("ISA alias forwarded downstream");

	a_reset_window: assert property ( // (RULE11)
		$rose(rst_n) |-> win[0].io_base == `BDEC_ZERO32 && win[0].io_limit == {20'h0_0000, `BDEC_IO_LIMIT_PAD}
		&& win[1].io_limit == {20'h0_0000, `BDEC_IO_LIMIT_PAD})
		else $error("I/O window not at reset value");

	a_io_upper_rw: assert property ( // (RULE9)
		s_wr_io_up0 ##1 !cfg_wr |-> win[0].io_base[31:16] == $past(cfg_wdata[15:0], 1)
		&& win[0].io_limit[31:16] == $past(cfg_wdata[31:16], 1))
		else $error("upper I/O halfwords not stored");

	a_cap_nibble: assert property ( // (RULE8)
		s_rd_io_low |=> cfg_rdata[3:0] == `BDEC_IO_CAP_NIB && cfg_rdata[11:8] == `BDEC_IO_CAP_NIB
		&& cfg_rdata[31:16] == `BDEC_RD_PAD16)
		else $error("I/O capability nibble wrong");

	a_route_pulse: assert property ( // (RULE1)
		!req_valid[0] |=> !route_valid[0])
		else $error("route valid without request");

	a_sec1_master_off: assert property ( // (RULE4)
		req_valid[1] && !master_en[0] |=> route_dest[1] == BDEC_DEST_NONE)
		else $error("bus one request routed with master enable clear");

	a_prim_to_one: assert property ( // (RULE1)
		req_valid[0] && down_hit[0][0] |=> route_dest[0] == BDEC_DEST_BUS_ONE)
		else $error("primary hit on port one not sent to bus one");

	a_prim_to_two: assert property ( // (RULE1)
		req_valid[0] && !down_hit[0][0] && down_hit[0][1] |=> route_dest[0] == BDEC_DEST_BUS_TWO)
		else $error("primary hit on port two not sent to bus two");

	a_prim_no_hit: assert property ( // (RULE1)
		req_valid[0] && (down_hit[0] == 2'b00) |=> route_dest[0] == BDEC_DEST_NONE)
		else $error("primary miss claimed");

	a_own_local_one: assert property ( // (RULE15)
		req_valid[1] && win_hit[1][0] |=> route_dest[1] == BDEC_DEST_NONE)
		else $error("bus one request inside own window forwarded");

	a_own_local_two: assert property ( // (RULE15)
		req_valid[2] && win_hit[2][1] |=> route_dest[2] == BDEC_DEST_NONE)
		else $error("bus two request inside own window forwarded");

	a_peer_route_one: assert property ( // (RULE2)
		req_valid[2] && master_en[1] && !win_hit[2][1] && down_hit[2][0] |=> route_dest[2] == BDEC_DEST_BUS_ONE)
		else $error("peer hit not routed to bus one");

	a_upstream_two: assert property ( // (RULE1)
		s_two_req(win_hit[2][1], down_hit[2][0]) |=> route_dest[2] == BDEC_DEST_PRIMARY)
		else $error("bus two miss not routed upstream");

	a_no_self_one: assert property ( // (RULE2)
		req_valid[1] |=> route_dest[1] != BDEC_DEST_BUS_ONE)
		else $error("bus one request routed back to bus one");

	a_no_self_two: assert property ( // (RULE2)
		req_valid[2] |=> route_dest[2] != BDEC_DEST_BUS_TWO)
		else $error("bus two request routed back to bus two");

	a_valid_follow: assert property ( // (RULE1)
		req_valid != 3'h0 |=> route_valid == $past(req_valid))
		else $error("route valid does not follow request");

	a_dest_hold: assert property ( // (RULE1)
		!req_valid[0] |=> $stable(route_dest[0]))
		else $error("primary route changed without request");

	a_rdata_hold: assert property ( // (RULE9)
		!cfg_rd |=> $stable(cfg_rdata))
		else $error("read data changed without a read");

	a_io_base_nib: assert property ( // (RULE8)
		s_wr_io_low0 ##0 cfg_be[0] |=> win[0].io_base[15:12] == $past(cfg_wdata[7:4]))
		else $error("I/O base nibble not stored");

	a_io_limit_nib: assert property ( // (RULE10)
		s_wr_io_low0 ##0 cfg_be[1] |=> win[0].io_limit[15:12] == $past(cfg_wdata[15:12]))
		else $error("I/O limit nibble not stored");

	a_io_above_isa: assert property ( // (RULE14)
		req_valid[0] && req_is_io[0] && io_en[0] && ((req_addr[0] & `BDEC_ISA_REGION_MASK) != `BDEC_ZERO32)
		&& bdec_in_window(req_addr[0], win[0].io_base, win[0].io_limit) |=> route_dest[0] == BDEC_DEST_BUS_ONE)
		else $error("I/O above 64KB not decoded by window alone");

endmodule
`default_nettype wire

// ---- core/bdec_pkg.sv ----
// Bridge address decoder: shared types and window compare
package bdec_pkg;

	typedef enum logic [1:0] {
		BDEC_DEST_NONE,
		BDEC_DEST_PRIMARY,
		BDEC_DEST_BUS_ONE,
		BDEC_DEST_BUS_TWO
	} bdec_dest_t;

	// Inclusive compare over all 32 address bits
	function automatic logic bdec_in_window(input logic [31:0] addr, input logic [31:0] base,
		input logic [31:0] limit);
		bdec_in_window = (addr >= base) && (addr <= limit);
	endfunction

endpackage

// ---- core/bdec_port_dec.sv ----
// Bridge address decoder: one address against one port's windows
`timescale 1ns/10ps
`default_nettype none
`include "bdec_regs.svh"
module bdec_port_dec
	import bdec_pkg::*;
(
	input  wire logic [31:0] addr,
	input  wire logic        is_io,
	input  wire logic        isa_en,
	input  wire logic        io_en,
	input  wire logic        mem_en,
	bdec_win_if.dec          win,
	output logic             win_hit,
	output logic             down_hit
);

	logic isa_hole;
	logic io_in;
	logic mem_in;

	// (RULE12) ISA mode drops upper 768 bytes of each 1KB below 64KB
	// (RULE14) above 64KB only the window counts
	assign isa_hole = is_io && isa_en && ((addr & `BDEC_ISA_REGION_MASK) == `BDEC_ZERO32)
		&& ((addr & `BDEC_ISA_ALIAS_MASK) != `BDEC_ZERO32);

	// (RULE19) inclusive 32-bit compare; (RULE6) base above limit never hits
	assign io_in  = bdec_in_window(addr, win.io_base, win.io_limit);
	assign mem_in = bdec_in_window(addr, win.np_base, win.np_limit)
		|| bdec_in_window(addr, win.pf_base, win.pf_limit);

	assign win_hit = is_io ? (io_in && !isa_hole) : mem_in;

	// (RULE3) (RULE5) downstream gated by I/O or memory enable
	assign down_hit = win_hit && (is_io ? io_en : mem_en);

endmodule
`default_nettype wire

// ---- core/bdec_regs.svh ----
// Bridge address decoder: configuration offsets, field values and masks
`ifndef BDEC_REGS_SVH
`define BDEC_REGS_SVH

// ----------------------------------------------------------------------------
// Configuration byte offsets
// ----------------------------------------------------------------------------
`define BDEC_OFF_IO_BASE_LOW   8'h1C
`define BDEC_OFF_IO_LIMIT_LOW  8'h1D
`define BDEC_OFF_NP_BASE       8'h20
`define BDEC_OFF_NP_LIMIT      8'h22
`define BDEC_OFF_PF_BASE       8'h24
`define BDEC_OFF_PF_LIMIT      8'h26
`define BDEC_OFF_IO_BASE_UP    8'h30
`define BDEC_OFF_IO_LIMIT_UP   8'h32

// ----------------------------------------------------------------------------
// Fixed low nibbles and reset values
// ----------------------------------------------------------------------------
`define BDEC_IO_CAP_NIB        4'h1
`define BDEC_NP_LOW_NIB        4'h0
`define BDEC_PF_CAP_NIB        4'h1
`define BDEC_RST_IO_NIB        4'h0
`define BDEC_RST_UP16          16'h0000
`define BDEC_RST_MEM12         12'h000
`define BDEC_RD_UNMAPPED       32'h0000_0000
`define BDEC_RD_PAD16          16'h0000

// ----------------------------------------------------------------------------
// Window expansion and ISA aliasing
// ----------------------------------------------------------------------------
`define BDEC_IO_BASE_PAD       12'h000
`define BDEC_IO_LIMIT_PAD      12'hFFF
`define BDEC_MEM_BASE_PAD      20'h0_0000
`define BDEC_MEM_LIMIT_PAD     20'hF_FFFF
`define BDEC_ISA_REGION_MASK   32'hFFFF_0000
`define BDEC_ISA_ALIAS_MASK    32'h0000_0300
`define BDEC_ZERO32            32'h0000_0000

`endif

// ---- core/bdec_win_if.sv ----
// Bridge address decoder: expanded window bundle of one secondary port
`timescale 1ns/10ps
`default_nettype none
interface bdec_win_if;
	logic [31:0] io_base;
	logic [31:0] io_limit;
	logic [31:0] np_base;
	logic [31:0] np_limit;
	logic [31:0] pf_base;
	logic [31:0] pf_limit;
	modport cfg (output io_base, io_limit, np_base, np_limit, pf_base, pf_limit);
	modport dec (input io_base, io_limit, np_base, np_limit, pf_base, pf_limit);
endinterface
`default_nettype wire

// ---- dv/bdec_bus_agents.sv ----
// Bridge address decoder: behavioural PCI agents issuing transactions on the three buses
`timescale 1ns/10ps
`default_nettype none
module bdec_bus_agents (
	input  wire logic        sys_clk,
	input  wire logic        cfg_wr,
	output logic      [2:0]  req_valid,
	output logic      [2:0]  req_is_io,
	output logic      [31:0] req_addr [3]
);
	initial begin
		req_valid = 3'h0;
		req_is_io = 3'h0;
		req_addr  = '{32'h0000_0000, 32'h0000_0000, 32'h0000_0000};
	end

	// -------------------------------------------------------------------
	// One address phase on bus src
	// -------------------------------------------------------------------
	task automatic issue(input int src, input logic io, input logic [31:0] addr);
		@(posedge sys_clk);
		while (cfg_wr === 1'b1)
			@(posedge sys_clk);
		req_valid[src] <= 1'b1;
		req_is_io[src] <= io;
		req_addr[src]  <= addr;
		@(posedge sys_clk);
		req_valid[src] <= 1'b0;
		// Released lines show the inverse, so a stale copy cannot pass
		req_is_io[src] <= ~io;
		req_addr[src]  <= ~addr;
	endtask
endmodule
`default_nettype wire

// ---- dv/bdec_decoder_tb_top.sv ----
// Bridge address decoder: self-checking testbench
`timescale 1ns/10ps
`default_nettype none
module bdec_decoder_tb_top;
	import bdec_pkg::*;

	typedef struct packed {
		logic [1:0]  src;
		logic        io;
		logic [31:0] addr;
		bdec_dest_t  dest;
	} bdec_row_t;

	localparam bdec_row_t ROWS [18] = '{
		'{2'd0, 1'b1, 32'h0000_2000, BDEC_DEST_BUS_ONE},
		'{2'd0, 1'b1, 32'h0000_1FFF, BDEC_DEST_NONE},
		'{2'd0, 1'b1, 32'h0000_3FFF, BDEC_DEST_BUS_ONE},
		'{2'd0, 1'b1, 32'h0000_4000, BDEC_DEST_NONE},
		'{2'd0, 1'b1, 32'h0001_8000, BDEC_DEST_BUS_TWO},
		'{2'd0, 1'b0, 32'h1000_0000, BDEC_DEST_BUS_ONE},
		'{2'd0, 1'b0, 32'h10FF_FFFF, BDEC_DEST_BUS_ONE},
		'{2'd0, 1'b0, 32'h1100_0000, BDEC_DEST_NONE},
		'{2'd0, 1'b0, 32'h200F_FFFF, BDEC_DEST_BUS_TWO},
		'{2'd1, 1'b1, 32'h0000_2100, BDEC_DEST_NONE},
		'{2'd1, 1'b1, 32'h0000_5000, BDEC_DEST_PRIMARY},
		'{2'd1, 1'b1, 32'h0001_0000, BDEC_DEST_BUS_TWO},
		'{2'd1, 1'b0, 32'h2000_0000, BDEC_DEST_BUS_TWO},
		'{2'd1, 1'b0, 32'h3000_0000, BDEC_DEST_PRIMARY},
		'{2'd2, 1'b1, 32'h0000_3000, BDEC_DEST_BUS_ONE},
		'{2'd2, 1'b1, 32'h0001_FFFF, BDEC_DEST_NONE},
		'{2'd2, 1'b0, 32'h1080_0000, BDEC_DEST_BUS_ONE},
		'{2'd2, 1'b0, 32'h2010_0000, BDEC_DEST_PRIMARY}
	};

	logic        sys_clk;
	logic        rst_n;
	logic        cfg_wr;
	logic        cfg_rd;
	logic        cfg_port;
	logic [7:0]  cfg_addr;
	logic [3:0]  cfg_be;
	logic [31:0] cfg_wdata;
	logic [31:0] cfg_rdata;
	logic [1:0]  io_en;
	logic [1:0]  mem_en;
	logic [1:0]  master_en;
	logic [1:0]  isa_en;
	logic [2:0]  req_valid;
	logic [2:0]  req_is_io;
	logic [31:0] req_addr [3];
	logic [2:0]  route_valid;
	bdec_dest_t  route_dest [3];
	int          miscompares;
	int          compares;

	bdec_decoder u_dut (
		.sys_clk(sys_clk), .rst_n(rst_n), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_port(cfg_port),
		.cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
		.io_en(io_en), .mem_en(mem_en), .master_en(master_en), .isa_en(isa_en),
		.req_valid(req_valid), .req_is_io(req_is_io), .req_addr(req_addr),
		.route_valid(route_valid), .route_dest(route_dest)
	);

	bdec_bus_agents u_agents (
		.sys_clk(sys_clk), .cfg_wr(cfg_wr), .req_valid(req_valid), .req_is_io(req_is_io),
		.req_addr(req_addr)
	);

	// -------------------------------------------------------------------
	// Clock, shared tasks
	// -------------------------------------------------------------------
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wrap_up();
		$display("Comparisons %0d, mismatches %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic cfg_write(input logic port, input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
		@(posedge sys_clk);
		cfg_wr    <= 1'b1;
		cfg_port  <= port;
		cfg_addr  <= a;
		cfg_be    <= be;
		cfg_wdata <= d;
		@(posedge sys_clk);
		cfg_wr    <= 1'b0;
		cfg_wdata <= ~d;
	endtask

	task automatic cfg_read(input logic port, input logic [7:0] a, input logic [31:0] exp);
		@(posedge sys_clk);
		cfg_rd   <= 1'b1;
		cfg_port <= port;
		cfg_addr <= a;
		@(posedge sys_clk);
		cfg_rd <= 1'b0;
		#1;
		check(cfg_rdata, exp);
	endtask

	// Result lands one cycle after the request edge
	task automatic decode(input int src, input logic io, input logic [31:0] a, input bdec_dest_t exp);
		u_agents.issue(src, io, a);
		#1;
		check({31'h0, route_valid[src]}, 32'h0000_0001);
		check({30'h0, route_dest[src]}, {30'h0, exp});
	endtask

	task automatic do_reset(input int cycles);
		rst_n <= 1'b0;
		repeat (cycles) @(posedge sys_clk);
		rst_n <= 1'b1;
	endtask

	initial begin
		repeat (5000) @(posedge sys_clk);
		miscompares++;
		wrap_up();
	end

	// -------------------------------------------------------------------
	// Main sequence
	// -------------------------------------------------------------------
	initial begin
		miscompares = 0;
		compares    = 0;
		cfg_wr = 1'b0;
		cfg_rd = 1'b0;
		cfg_port = 1'b0;
		cfg_addr = 8'h00;
		cfg_be = 4'h0;
		cfg_wdata = 32'h0000_0000;
		{io_en, mem_en, master_en, isa_en} = 8'h00;
		do_reset(12);
		cfg_read(1'b0, 8'h1C, 32'h0000_0101);
		cfg_read(1'b1, 8'h30, 32'h0000_0000);
		io_en <= 2'h1;
		decode(0, 1'b1, 32'h0000_0FFF, BDEC_DEST_BUS_ONE);
		decode(0, 1'b1, 32'h0000_1000, BDEC_DEST_NONE);
		io_en <= 2'h0;
		decode(0, 1'b1, 32'h0000_0FFF, BDEC_DEST_NONE);
		decode(0, 1'b0, 32'h0000_0000, BDEC_DEST_NONE);
		cfg_write(1'b0, 8'h1C, 4'h3, 32'hFFFF_3020);
		cfg_write(1'b1, 8'h1C, 4'h3, 32'h0000_F000);
		cfg_write(1'b1, 8'h30, 4'hF, 32'h0001_0001);
		cfg_write(1'b0, 8'h20, 4'hF, 32'h10F0_1000);
		cfg_write(1'b1, 8'h24, 4'hF, 32'h2000_2000);
		cfg_write(1'b0, 8'h40, 4'hF, 32'hA5A5_A5A5);
		cfg_read(1'b0, 8'h1C, 32'h0000_3121);
		cfg_read(1'b1, 8'h1C, 32'h0000_F101);
		cfg_read(1'b1, 8'h30, 32'h0001_0001);
		cfg_read(1'b0, 8'h20, 32'h10F0_1000);
		cfg_read(1'b1, 8'h24, 32'h2001_2001);
		cfg_read(1'b0, 8'h40, 32'h0000_0000);
		// enables only after windows are set
		{io_en, mem_en, master_en} <= 6'h3F;
		for (int i = 0; i < 18; i++)
			decode(ROWS[i].src, ROWS[i].io, ROWS[i].addr, ROWS[i].dest);
		io_en  <= 2'h2;
		mem_en <= 2'h2;
		decode(0, 1'b1, 32'h0000_2000, BDEC_DEST_NONE);
		decode(0, 1'b0, 32'h1000_0000, BDEC_DEST_NONE);
		decode(2, 1'b0, 32'h1080_0000, BDEC_DEST_PRIMARY);
		{io_en, mem_en, master_en} <= 6'h3E;
		decode(1, 1'b1, 32'h0000_5000, BDEC_DEST_NONE);
		decode(1, 1'b0, 32'h3000_0000, BDEC_DEST_NONE);
		master_en <= 2'h1;
		decode(2, 1'b0, 32'h2010_0000, BDEC_DEST_NONE);
		master_en <= 2'h3;
		// base above limit turns the window off
		cfg_write(1'b0, 8'h1C, 4'h1, 32'h0000_0050);
		decode(0, 1'b1, 32'h0000_3000, BDEC_DEST_NONE);
		decode(1, 1'b1, 32'h0000_3000, BDEC_DEST_PRIMARY);
		cfg_write(1'b0, 8'h1C, 4'h1, 32'h0000_0020);
		isa_en <= 2'h3;
		decode(0, 1'b1, 32'h0000_20FF, BDEC_DEST_BUS_ONE);
		decode(0, 1'b1, 32'h0000_2100, BDEC_DEST_NONE);
		decode(0, 1'b1, 32'h0000_2400, BDEC_DEST_BUS_ONE);
		decode(1, 1'b1, 32'h0000_2300, BDEC_DEST_PRIMARY);
		decode(1, 1'b1, 32'h0000_2000, BDEC_DEST_NONE);
		decode(0, 1'b1, 32'h0001_0100, BDEC_DEST_BUS_TWO);
		decode(2, 1'b1, 32'h0001_0300, BDEC_DEST_NONE);
		// port one upper halves move its window above 64KB
		cfg_write(1'b0, 8'h30, 4'hF, 32'h0003_0002);
		cfg_read(1'b0, 8'h30, 32'h0003_0002);
		decode(0, 1'b1, 32'h0002_2000, BDEC_DEST_BUS_ONE);
		do_reset(2);
		#1;
		check({29'h0, route_valid}, 32'h0000_0000);
		check({30'h0, route_dest[0]}, {30'h0, BDEC_DEST_NONE});
		cfg_read(1'b1, 8'h30, 32'h0000_0000);
		cfg_read(1'b0, 8'h30, 32'h0000_0000);
		cfg_read(1'b0, 8'h1C, 32'h0000_0101);
		wrap_up();
	end
endmodule
`default_nettype wire
